/* File: rsp_consts.vh */
// Constants for the serial host port: timing counts, format codes, frame layout.
// Assumes a 40 MHz core clock; included by the port module and the testbench.
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH
`define RSP_CLK_HZ 40000000
// Baud select codes
`define RSP_BAUD_300 3'h0
`define RSP_BAUD_600 3'h1
`define RSP_BAUD_1200 3'h2
`define RSP_BAUD_2400 3'h3
`define RSP_BAUD_4800 3'h4
`define RSP_BAUD_9600 3'h5
`define RSP_BAUD_RST 3'h5
// Cycles per bit at each rate (rounded down)
`define RSP_DIV_300 (`RSP_CLK_HZ / 300)
`define RSP_DIV_600 (`RSP_CLK_HZ / 600)
`define RSP_DIV_1200 (`RSP_CLK_HZ / 1200)
`define RSP_DIV_2400 (`RSP_CLK_HZ / 2400)
`define RSP_DIV_4800 (`RSP_CLK_HZ / 4800)
`define RSP_DIV_9600 (`RSP_CLK_HZ / 9600)
// Format codes
`define RSP_FMT_NONE8 2'h0
`define RSP_FMT_EVEN7 2'h1
`define RSP_FMT_ODD7 2'h2
`define RSP_FMT_RST 2'h0
// Frame layout: start, 8 payload slots, 2 stops
`define RSP_START_BITS 1
`define RSP_STOP_BITS 2
`define RSP_SLOT_BITS 8
// Register map (word index on the plain port)
`define RSP_REG_CTRL 2'h0
`define RSP_REG_STAT 2'h1
`define RSP_REG_TXD 2'h2
`define RSP_REG_RXD 2'h3
// Control fields, then transmit FIFO size
`define RSP_CTRL_BAUD_LSB 0
`define RSP_CTRL_FMT_LSB 4
`define RSP_CTRL_TR_BIT 8
`define RSP_FIFO_DEPTH 8
`define RSP_FIFO_AW 3
`endif

/* File: rsp_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module rsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire core_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doWrite;
  wire doRead;

  // Full and empty come straight from the occupancy count
  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData = mem[rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // Storage array has no reset; only the pointers and the count matter
  always @(posedge core_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointer and count update
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
        count <= count + 1'b1;
      end else if (doRead && !doWrite) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // rsp_fifo

/* File: rsp_host.sv */
// Host terminal model: receives transmit frames, sends frames, set-ready.
// Assumes 9600 baud at a 40 MHz clock; bench sets hold to stall it.
`timescale 1ns/1ps
module rsp_host (
  input wire core_clk,
  input wire txLine,
  input wire termReady,
  output logic rxLine,
  output wire setReady
);
  localparam int BT = 4166;
  logic hold = 1'b0;
  logic [10:0] fr;
  logic [10:0] got[$];
  assign setReady = !hold;
  initial rxLine = 1'b1;
  // Sample mid-bit; the last stop is not waited out, so gaps are short
  always begin
    @(negedge txLine);
    repeat (BT / 2) @(posedge core_clk);
    for (int i = 0; i < 11; i++) begin
      fr[i] = txLine;
      if (i < 10) repeat (BT) @(posedge core_clk);
    end
    got.push_back(fr);
  end
  // Send one frame once the device is ready
  task automatic send(input [10:0] f);
    while (termReady !== 1'b1) @(posedge core_clk);
    for (int i = 0; i < 11; i++) begin
      rxLine <= f[i];
      repeat (BT) @(posedge core_clk);
    end
  endtask
endmodule // rsp_host

/* File: rsp_port_chk.sv */
// Checker for the serial host port: frame timing, pacing, register reads.
// Assumes 9600 baud whenever frames are sent.
`timescale 1ns/1ps
module rsp_port_chk (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regRdData,
  input wire rxLine,
  input wire txLine,
  input wire termReady,
  input wire setReady
);
  localparam int BT = 4166;
  int fCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Frame position; slower rates would trip the bit checks
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) fCnt <= 0;
    else if (fCnt == 0) fCnt <= $fell(txLine) ? 1 : 0;
    else fCnt <= (fCnt == 11 * BT - 1) ? 0 : fCnt + 1;
  end
  a_start_low: assert property (fCnt > 0 && fCnt < BT |-> !txLine)
    else $error("start bit not low");
  a_stop_high: assert property (fCnt >= 9 * BT |-> txLine)
    else $error("stop bits not high");
  a_bit_steady: assert property (fCnt > 0 && fCnt % BT != 0 |-> $stable(txLine))
    else $error("bit changed inside its time");
  a_rd_answer: assert property (regRdData != 16'h0 |-> $past(regRead))
    else $error("read data outside answer cycle");
  a_txd_reads0: assert property ($past(regRead) && $past(regAddr) == 2'h2
    |-> regRdData == 16'h0) else $error("transmit index read not zero");
  a_tx_paced: assert property (fCnt == 0 && !$past(setReady)
    && !$past(setReady, 2) && !$past(setReady, 3) |-> txLine)
    else $error("frame started without set-ready");
  a_tr_rise: assert property ($rose(termReady) |-> $past(regWrite, 2)
    || $past(regRead) || $past(regRead, 2) || $past(regRead, 3))
    else $error("terminal-ready rose without cause");
  a_tr_drop: assert property ($fell(termReady) |-> rxLine
    || $past(regWrite, 2)) else $error("terminal-ready fell outside stop");
  cover property (fCnt == 11 * BT - 1);
  cover property ($fell(termReady));
  cover property (regRdData != 16'h0);
endmodule // rsp_port_chk
bind rsp_serial_port rsp_port_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .rxLine(rxLine), .txLine(txLine),
  .termReady(termReady), .setReady(setReady));

/* File: rsp_serial_port.v */
// Asynchronous serial host port: transmitter fed by an 8-word FIFO, receiver,
// terminal-ready / set-ready pacing, and a small register port.
// Assumes 40 MHz core_clk, serial and handshake inputs synchronous to it.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "rsp_consts.vh"

// Functional notes
// - Rates 300 to 9600 baud, default 9600
// - Formats: none/8 default, even/7, odd/7
// - Exactly one start bit, fixed
// - Exactly two stop bits, fixed
// - Order: start, data, parity, two stops
// - Settings latched for whole frame span
// - Pace traffic with ready handshake lines
module rsp_serial_port (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdData,
  input wire rxLine,
  output reg txLine,
  output reg termReady,
  input wire setReady
);
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam RX_IDLE = 2'h0;
  localparam RX_SHIFT = 2'h1;

  reg [2:0] baudSel;
  reg [1:0] fmtSel;
  reg termEnable;
  reg [1:0] txState;
  // Bit timers are 18 bits wide: the slowest rate needs more than 16 bits of count
  reg [17:0] txDivCnt;
  reg [3:0] txBitCnt;
  reg [10:0] txShift;
  reg [1:0] rxState;
  reg [17:0] rxDivCnt;
  reg [17:0] rxBitLen;
  reg [1:0] rxFmt;
  reg [3:0] rxBitCnt;
  reg [10:0] rxShift;
  reg [7:0] rxData;
  reg rxFull;
  reg rxOverrun;
  reg rxFrameErr;
  reg rxParityErr;
  reg [17:0] txBitLen;
  reg rxPrev;
  wire fifoInReady;
  wire [7:0] fifoOutData;
  wire fifoOutValid;
  wire fifoPop;
  wire txWrite;
  wire rxRead;

  // Cycles per bit for a baud select code
  // The divider constants are plain integers; the count is cut to the timer width on purpose
  function [17:0] bitLen;
    input [2:0] sel;
    integer cyc;
    begin
      case (sel)
        `RSP_BAUD_300: cyc = `RSP_DIV_300;
        `RSP_BAUD_600: cyc = `RSP_DIV_600;
        `RSP_BAUD_1200: cyc = `RSP_DIV_1200;
        `RSP_BAUD_2400: cyc = `RSP_DIV_2400;
        `RSP_BAUD_4800: cyc = `RSP_DIV_4800;
        default: cyc = `RSP_DIV_9600;
      endcase
      bitLen = cyc[17:0];
    end
  endfunction

  // Frame payload slots: seven data plus parity, or eight data
  function [7:0] payload;
    input [1:0] fmt;
    input [7:0] d;
    begin
      case (fmt)
        `RSP_FMT_EVEN7: payload = {^d[6:0], d[6:0]};
        `RSP_FMT_ODD7: payload = {~^d[6:0], d[6:0]};
        default: payload = d;
      endcase
    end
  endfunction

  assign txWrite = regWrite && (regAddr == `RSP_REG_TXD);
  assign rxRead = regRead && (regAddr == `RSP_REG_RXD);
  // Only start a frame when the host says it is ready; a frame in flight finishes
  assign fifoPop = (txState == TX_IDLE) && setReady;

  // Outgoing characters wait here; writes while full are dropped, visible in status
  rsp_fifo #(
    .WIDTH(8),
    .DEPTH(`RSP_FIFO_DEPTH),
    .AW(`RSP_FIFO_AW)
  ) txFifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inData(regWrData[7:0]),
    .inValid(txWrite),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoPop)
  );

  // Control register writes
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      baudSel <= `RSP_BAUD_RST;
      fmtSel <= `RSP_FMT_RST;
      termEnable <= 1'b0;
    end else if (regWrite && (regAddr == `RSP_REG_CTRL)) begin
      // Undefined codes fall back to the defaults so only listed modes exist
      baudSel <= (regWrData[`RSP_CTRL_BAUD_LSB+2:`RSP_CTRL_BAUD_LSB] > `RSP_BAUD_9600) ?
        `RSP_BAUD_RST : regWrData[`RSP_CTRL_BAUD_LSB+2:`RSP_CTRL_BAUD_LSB];
      fmtSel <= (regWrData[`RSP_CTRL_FMT_LSB+1:`RSP_CTRL_FMT_LSB] > `RSP_FMT_ODD7) ?
        `RSP_FMT_RST : regWrData[`RSP_CTRL_FMT_LSB+1:`RSP_CTRL_FMT_LSB];
      termEnable <= regWrData[`RSP_CTRL_TR_BIT];
    end
  end

  // Transmitter: 11-bit frame, rate latched at frame start
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txState <= TX_IDLE;
      txDivCnt <= 18'h00000;
      txBitCnt <= 4'h0;
      txShift <= 11'h7FF;
      txBitLen <= 18'h00000;
      txLine <= 1'b1;
    end else begin
      case (txState)
        TX_IDLE: begin
          txLine <= 1'b1;
          if (fifoPop && fifoOutValid) begin
            // Stops, payload LSB first, one start bit
            txShift <= {2'b11, payload(fmtSel, fifoOutData), 1'b0};
            txBitLen <= bitLen(baudSel);
            txDivCnt <= 18'h00000;
            txBitCnt <= 4'h0;
            txState <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          txLine <= txShift[0];
          if (txDivCnt == txBitLen - 18'h00001) begin
            txDivCnt <= 18'h00000;
            txShift <= {1'b1, txShift[10:1]};
            // Frame ends after the second stop bit
            if (txBitCnt == 4'hA) begin
              txState <= TX_IDLE;
            end else begin
              txBitCnt <= txBitCnt + 4'h1;
            end
          end else begin
            txDivCnt <= txDivCnt + 18'h00001;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // Receiver: samples mid-bit, format and rate latched at the start edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      rxDivCnt <= 18'h00000;
      rxBitLen <= 18'h00000;
      rxFmt <= `RSP_FMT_RST;
      rxBitCnt <= 4'h0;
      rxShift <= 11'h000;
      rxData <= 8'h00;
      rxFull <= 1'b0;
      rxOverrun <= 1'b0;
      rxFrameErr <= 1'b0;
      rxParityErr <= 1'b0;
      rxPrev <= 1'b1;
    end else begin
      rxPrev <= rxLine;
      // Reading the data clears the flags; a new character in the same cycle wins
      if (rxRead) begin
        rxFull <= 1'b0;
        rxOverrun <= 1'b0;
        rxFrameErr <= 1'b0;
        rxParityErr <= 1'b0;
      end
      case (rxState)
        RX_IDLE: begin
          if (rxPrev && !rxLine) begin
            rxBitLen <= bitLen(baudSel);
            rxFmt <= fmtSel;
            // Start half a bit in so every later sample lands mid-bit
            rxDivCnt <= bitLen(baudSel) >> 1;
            rxBitCnt <= 4'h0;
            rxState <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (rxDivCnt == rxBitLen - 18'h00001) begin
            rxDivCnt <= 18'h00000;
            rxShift <= {rxLine, rxShift[10:1]};
            if (rxBitCnt == 4'h0 && rxLine) begin
              // Glitch, not a real start bit
              rxState <= RX_IDLE;
            end else if (rxBitCnt == 4'hA) begin
              rxState <= RX_IDLE;
              rxData <= (rxFmt == `RSP_FMT_NONE8) ? rxShift[9:2] : {1'b0, rxShift[8:2]};
              rxFull <= 1'b1;
              rxOverrun <= rxOverrun | (rxFull & ~rxRead);
              // Both stop bits must be high
              rxFrameErr <= ~(rxShift[10] & rxLine);
              rxParityErr <= (rxFmt == `RSP_FMT_EVEN7) ? (^rxShift[9:2]) :
                (rxFmt == `RSP_FMT_ODD7) ? ~(^rxShift[9:2]) : 1'b0;
            end else begin
              rxBitCnt <= rxBitCnt + 4'h1;
            end
          end else begin
            rxDivCnt <= rxDivCnt + 18'h00001;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Terminal ready: raised by software once it can take characters, dropped while unread data
  // is pending so the host holds off instead of overrunning
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      termReady <= 1'b0;
    end else begin
      termReady <= termEnable & ~rxFull;
    end
  end

  // Read port: data stands one cycle after the strobe only
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      if (regAddr == `RSP_REG_CTRL) begin
        regRdData <= {7'h00, termEnable, 2'h0, fmtSel, 1'b0, baudSel};
      end else if (regAddr == `RSP_REG_STAT) begin
        regRdData <= {7'h00, setReady, (txState != TX_IDLE), fifoOutValid, ~fifoInReady,
          rxParityErr, rxFrameErr, rxOverrun, rxFull, termReady};
      end else if (regAddr == `RSP_REG_RXD) begin
        regRdData <= {8'h00, rxData};
      end else begin
        regRdData <= 16'h0000;
      end
    end else begin
      regRdData <= 16'h0000;
    end
  end
endmodule // rsp_serial_port

/* File: rsp_tb.sv */
// Testbench for the serial host port: registers, queue fill, both frame directions.
// Assumes the host model and about 100k cycles at 40 MHz.
`timescale 1ns/1ps
`include "rsp_consts.vh"
module tb;
  logic core_clk, rst_n, regWrite, regRead;
  logic [1:0] regAddr;
  logic [15:0] regWrData, q;
  logic [31:0] rnd;
  logic [7:0] d1, d2;
  wire [15:0] regRdData;
  wire rxLine, txLine, termReady, setReady;
  int n_fail, compares;
  rsp_serial_port uut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .rxLine(rxLine), .txLine(txLine),
    .termReady(termReady), .setReady(setReady));
  rsp_host u_host (.core_clk(core_clk), .txLine(txLine), .termReady(termReady),
    .rxLine(rxLine), .setReady(setReady));
  function automatic [31:0] lfsr(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference frame: start, payload LSB first, two stops
  function automatic [10:0] mk(input [7:0] d, input [1:0] f);
    logic [7:0] p;
    p = (f == `RSP_FMT_NONE8) ? d : {(f == `RSP_FMT_ODD7) ^ (^d[6:0]), d[6:0]};
    return {2'b11, p, 1'b0};
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [1:0] a, input [15:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input [1:0] a);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 q = regRdData;
  endtask
  task wgot(input int n);
    for (int k = 0; k < 60000 && u_host.got.size() < n; k++) @(posedge core_clk);
  endtask
  task finish_test;
    $display("compares %0d fails %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Watchdog sized a quarter above the expected run
  initial begin
    repeat (120000) @(posedge core_clk);
    n_fail++;
    finish_test;
  end
  initial begin
    rst_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 2'h0;
    regWrData = 16'h0;
    rnd = 32'hFD6E;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`RSP_REG_CTRL);
    chk("ctrl", 16'h0005, q);
    // Stall the host and fill the queue past its depth
    u_host.hold <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      wr(`RSP_REG_TXD, rnd[15:0]);
    end
    rd(`RSP_REG_STAT);
    chk("stat full", 16'h0060, q);
    chk("tx held", 16'h0001, {15'h0, txLine});
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`RSP_REG_STAT);
    chk("stat flushed", 16'h0000, q);
    $display("test fill done");
    wr(`RSP_REG_CTRL, 16'h0105);
    rnd = lfsr(rnd);
    d1 = rnd[7:0];
    d2 = rnd[15:8];
    wr(`RSP_REG_TXD, {8'h00, d1});
    u_host.hold <= 1'b0;
    // Bench has already set terminal-ready enable and released the host's set-ready before this exchange
    fork
      u_host.send(mk(d2, `RSP_FMT_NONE8));
      wgot(1);
    join
    chk("tx none8", {5'h0, mk(d1, `RSP_FMT_NONE8)}, {5'h0, u_host.got[0]});
    rd(`RSP_REG_STAT);
    chk("stat rx", 16'h0102, q & 16'h017F);
    rd(`RSP_REG_RXD);
    chk("rxd none8", {8'h00, d2}, q);
    repeat (4) @(posedge core_clk);
    rd(`RSP_REG_STAT);
    chk("stat ready", 16'h0101, q & 16'h017F);
    $display("test none8 done");
    // Format changes mid-frame; each frame keeps the one it began with
    rnd = lfsr(rnd);
    d1 = rnd[7:0];
    d2 = rnd[15:8];
    wr(`RSP_REG_CTRL, 16'h0115);
    wr(`RSP_REG_TXD, {8'h00, d1});
    repeat (4200) @(posedge core_clk);
    wr(`RSP_REG_CTRL, 16'h0125);
    fork
      u_host.send(mk(d2, `RSP_FMT_ODD7));
      wgot(2);
    join
    chk("tx even7", {5'h0, mk(d1, `RSP_FMT_EVEN7)}, {5'h0, u_host.got[1]});
    rd(`RSP_REG_STAT);
    chk("stat odd7", 16'h0102, q & 16'h017F);
    rd(`RSP_REG_RXD);
    chk("rxd odd7", {9'h0, d2[6:0]}, q);
    $display("test parity done");
    finish_test;
  end
endmodule // tb
